// >>> logic/pdc_regs.vh
`ifndef PDC_REGS_VH
`define PDC_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PDC_RX_CUR_ADDR_OFS 12'h100
`define PDC_RX_CUR_CNT_OFS 12'h104
`define PDC_TX_CUR_ADDR_OFS 12'h108
`define PDC_TX_CUR_CNT_OFS 12'h10C
`define PDC_RX_NXT_ADDR_OFS 12'h110
`define PDC_RX_NXT_CNT_OFS 12'h114
`define PDC_TX_NXT_ADDR_OFS 12'h118
`define PDC_TX_NXT_CNT_OFS 12'h11C
`define PDC_CMD_OFS 12'h120
`define PDC_STATE_OFS 12'h124
`define PDC_FLAGS_OFS 12'h128

// ****************************************************************
// field positions and widths
// ****************************************************************
`define PDC_CNT_W 16
`define PDC_RX_EN_BIT 0
`define PDC_RX_DIS_BIT 1
`define PDC_TX_EN_BIT 8
`define PDC_TX_DIS_BIT 9
`define PDC_FLAG_RX_END_BIT 0
`define PDC_FLAG_RX_FULL_BIT 1
`define PDC_FLAG_TX_END_BIT 2
`define PDC_FLAG_TX_EMPTY_BIT 3

// ****************************************************************
// reset values and size codes
// ****************************************************************
`define PDC_ADDR_RST 32'h0000_0000
`define PDC_CNT_RST 16'h0000
`define PDC_SIZE_BYTE 2'h0
`define PDC_SIZE_HALF 2'h1
`define PDC_SIZE_WORD 2'h2

`endif

// >>> logic/pdc_channel_pair.v
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.vh"

// Summary of operation
// [RULE1] eleven registers at 0x100 to 0x128 in word steps
// [RULE2] receive pointer is a full 32-bit next receive address
// [RULE3] receive counter holds remaining receive transfers in bits 15:0
// [RULE4] transmit pointer is a 32-bit address of next transmit fetch
// [RULE5] transmit counter 16 bits; at zero transmit movement stops
// [RULE6] receive next pointer holds address of chained receive buffer
// [RULE7] receive next counter holds chained receive count in 15:0
// [RULE8] transmit next pointer holds address of chained transmit buffer
// [RULE9] transmit next counter holds chained transmit count in 15:0
// [RULE10] command bit 0 enables receive unless bit 1 also set
// [RULE11] command bit 1 disables receive requests
// [RULE12] command bit 8 enables transmit requests
// [RULE13] command bit 9 disables transmit requests
// [RULE14] state bit 0 shows receive requests enabled
// [RULE15] state bit 8 shows transmit requests enabled
// [RULE16] after a transfer pointer grows by 1, 2 or 4; count drops one
// [RULE17] at zero count with nonzero next, reload from next and continue
// [RULE18] reloading clears the next counter; the code keeps it when the current counter is written in the same cycle
// [RULE19] end and both-end flags; cleared by writing either counter
// [RULE20] transmit enable with disable together leaves transmit disabled
// [RULE21] reserved bits ignore writes and read as zero
module pdc_channel_pair (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire peripheral_rx_request,
  input wire peripheral_tx_request,
  input wire [1:0] rx_size,
  input wire [1:0] tx_size,
  output wire rx_xfer_req,
  output wire [31:0] rx_xfer_addr,
  input wire rx_xfer_done,
  output wire tx_xfer_req,
  output wire [31:0] tx_xfer_addr,
  input wire tx_xfer_done,
  output wire rx_buffer_end_flag,
  output wire rx_all_buffers_full_flag,
  output wire tx_buffer_end_flag,
  output wire tx_all_buffers_empty_flag
);

  // ****************************************************************
  // register state
  // ****************************************************************
  reg [31:0] rx_address_field_q;
  reg [15:0] rx_count_field_q;
  reg [31:0] tx_address_field_q;
  reg [15:0] tx_count_field_q;
  reg [31:0] rx_chained_address_field_q;
  reg [15:0] rx_chained_count_field_q;
  reg [31:0] tx_chained_address_field_q;
  reg [15:0] tx_chained_count_field_q;
  reg rx_request_enable_q;
  reg tx_request_enable_q;

  wire wr_en;
  wire rd_en;
  wire cmd_wr;
  wire rx_cnt_wr;
  wire tx_cnt_wr;
  wire rx_step;
  wire tx_step;
  wire rx_reload;
  wire tx_reload;

  // byte, half-word or word increment
  function [31:0] step_of;
    input [1:0] size;
    begin
      if (size == `PDC_SIZE_WORD) begin
        step_of = 32'h0000_0004;
      end else if (size == `PDC_SIZE_HALF) begin
        step_of = 32'h0000_0002;
      end else begin
        step_of = 32'h0000_0001;
      end
    end
  endfunction

  function is_known;
    input [11:0] a;
    begin
      is_known = (a[1:0] == 2'h0) && (a >= `PDC_RX_CUR_ADDR_OFS) &&
        (a <= `PDC_FLAGS_OFS);
    end
  endfunction

  // ****************************************************************
  // apb slave: zero wait states, error on unmapped address
  // ****************************************************************
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_known(paddr);
  assign wr_en = psel & penable & pwrite & is_known(paddr);
  assign rd_en = psel & ~penable & ~pwrite;
  assign cmd_wr = wr_en && paddr == `PDC_CMD_OFS;
  assign rx_cnt_wr = wr_en && (paddr == `PDC_RX_CUR_CNT_OFS ||
    paddr == `PDC_RX_NXT_CNT_OFS); // RULE19
  assign tx_cnt_wr = wr_en && (paddr == `PDC_TX_CUR_CNT_OFS ||
    paddr == `PDC_TX_NXT_CNT_OFS); // RULE19

  // ****************************************************************
  // peripheral side: a request is served only while enabled and
  // the current count is nonzero
  // ****************************************************************
  assign rx_xfer_req = peripheral_rx_request & rx_request_enable_q &
    (rx_count_field_q != `PDC_CNT_RST); // RULE3
  assign tx_xfer_req = peripheral_tx_request & tx_request_enable_q &
    (tx_count_field_q != `PDC_CNT_RST); // RULE5
  assign rx_xfer_addr = rx_address_field_q; // RULE2
  assign tx_xfer_addr = tx_address_field_q; // RULE4
  assign rx_step = rx_xfer_req & rx_xfer_done;
  assign tx_step = tx_xfer_req & tx_xfer_done;
  // chain once the current buffer is exhausted
  assign rx_reload = (rx_count_field_q == `PDC_CNT_RST) &&
    (rx_chained_count_field_q != `PDC_CNT_RST); // RULE17
  assign tx_reload = (tx_count_field_q == `PDC_CNT_RST) &&
    (tx_chained_count_field_q != `PDC_CNT_RST); // RULE17

  // flags follow the counters directly, so a counter write clears them
  assign rx_buffer_end_flag = (rx_count_field_q == `PDC_CNT_RST); // RULE19
  assign rx_all_buffers_full_flag = rx_buffer_end_flag &&
    (rx_chained_count_field_q == `PDC_CNT_RST); // RULE19
  assign tx_buffer_end_flag = (tx_count_field_q == `PDC_CNT_RST); // RULE19
  assign tx_all_buffers_empty_flag = tx_buffer_end_flag &&
    (tx_chained_count_field_q == `PDC_CNT_RST); // RULE19

  // ****************************************************************
  // receive channel
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_address_field_q <= `PDC_ADDR_RST;
      rx_count_field_q <= `PDC_CNT_RST;
      rx_chained_address_field_q <= `PDC_ADDR_RST;
      rx_chained_count_field_q <= `PDC_CNT_RST;
    end else begin
      if (wr_en && paddr == `PDC_RX_CUR_ADDR_OFS) begin
        rx_address_field_q <= pwdata; // RULE2
      end else if (rx_step) begin
        rx_address_field_q <= rx_address_field_q + step_of(rx_size); // RULE16
      end else if (rx_reload) begin
        rx_address_field_q <= rx_chained_address_field_q; // RULE17
      end
      if (wr_en && paddr == `PDC_RX_CUR_CNT_OFS) begin
        rx_count_field_q <= pwdata[15:0]; // RULE21
      end else if (rx_step) begin
        rx_count_field_q <= rx_count_field_q - 16'h0001; // RULE16
      end else if (rx_reload) begin
        rx_count_field_q <= rx_chained_count_field_q; // RULE17
      end
      if (wr_en && paddr == `PDC_RX_NXT_ADDR_OFS) begin
        rx_chained_address_field_q <= pwdata; // RULE6
      end
      if (wr_en && paddr == `PDC_RX_NXT_CNT_OFS) begin
        rx_chained_count_field_q <= pwdata[15:0]; // RULE7
      end else if (rx_reload && !rx_cnt_wr) begin
        rx_chained_count_field_q <= `PDC_CNT_RST; // RULE18
      end
    end
  end

  // ****************************************************************
  // transmit channel
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_address_field_q <= `PDC_ADDR_RST;
      tx_count_field_q <= `PDC_CNT_RST;
      tx_chained_address_field_q <= `PDC_ADDR_RST;
      tx_chained_count_field_q <= `PDC_CNT_RST;
    end else begin
      if (wr_en && paddr == `PDC_TX_CUR_ADDR_OFS) begin
        tx_address_field_q <= pwdata; // RULE4
      end else if (tx_step) begin
        tx_address_field_q <= tx_address_field_q + step_of(tx_size); // RULE16
      end else if (tx_reload) begin
        tx_address_field_q <= tx_chained_address_field_q; // RULE17
      end
      if (wr_en && paddr == `PDC_TX_CUR_CNT_OFS) begin
        tx_count_field_q <= pwdata[15:0]; // RULE21
      end else if (tx_step) begin
        tx_count_field_q <= tx_count_field_q - 16'h0001; // RULE16
      end else if (tx_reload) begin
        tx_count_field_q <= tx_chained_count_field_q; // RULE17
      end
      if (wr_en && paddr == `PDC_TX_NXT_ADDR_OFS) begin
        tx_chained_address_field_q <= pwdata; // RULE8
      end
      if (wr_en && paddr == `PDC_TX_NXT_CNT_OFS) begin
        tx_chained_count_field_q <= pwdata[15:0]; // RULE9
      end else if (tx_reload && !tx_cnt_wr) begin
        tx_chained_count_field_q <= `PDC_CNT_RST; // RULE18
      end
    end
  end

  // ****************************************************************
  // enable commands: disable beats enable when both are written
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_request_enable_q <= 1'b0;
      tx_request_enable_q <= 1'b0;
    end else if (cmd_wr) begin
      if (pwdata[`PDC_RX_DIS_BIT]) begin
        rx_request_enable_q <= 1'b0; // RULE11
      end else if (pwdata[`PDC_RX_EN_BIT]) begin
        rx_request_enable_q <= 1'b1; // RULE10
      end
      if (pwdata[`PDC_TX_DIS_BIT]) begin
        tx_request_enable_q <= 1'b0; // RULE13 RULE20
      end else if (pwdata[`PDC_TX_EN_BIT]) begin
        tx_request_enable_q <= 1'b1; // RULE12
      end
    end
  end

  // ****************************************************************
  // read data, captured in the setup cycle
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      if (paddr == `PDC_RX_CUR_ADDR_OFS) begin
        prdata <= rx_address_field_q; // RULE1
      end else if (paddr == `PDC_RX_CUR_CNT_OFS) begin
        prdata <= {16'h0000, rx_count_field_q}; // RULE21
      end else if (paddr == `PDC_TX_CUR_ADDR_OFS) begin
        prdata <= tx_address_field_q;
      end else if (paddr == `PDC_TX_CUR_CNT_OFS) begin
        prdata <= {16'h0000, tx_count_field_q};
      end else if (paddr == `PDC_RX_NXT_ADDR_OFS) begin
        prdata <= rx_chained_address_field_q;
      end else if (paddr == `PDC_RX_NXT_CNT_OFS) begin
        prdata <= {16'h0000, rx_chained_count_field_q};
      end else if (paddr == `PDC_TX_NXT_ADDR_OFS) begin
        prdata <= tx_chained_address_field_q;
      end else if (paddr == `PDC_TX_NXT_CNT_OFS) begin
        prdata <= {16'h0000, tx_chained_count_field_q};
      end else if (paddr == `PDC_STATE_OFS) begin
        prdata[`PDC_RX_EN_BIT] <= rx_request_enable_q; // RULE14
        prdata[`PDC_TX_EN_BIT] <= tx_request_enable_q; // RULE15
      end else if (paddr == `PDC_FLAGS_OFS) begin
        prdata[`PDC_FLAG_RX_END_BIT] <= rx_buffer_end_flag;
        prdata[`PDC_FLAG_RX_FULL_BIT] <= rx_all_buffers_full_flag;
        prdata[`PDC_FLAG_TX_END_BIT] <= tx_buffer_end_flag;
        prdata[`PDC_FLAG_TX_EMPTY_BIT] <= tx_all_buffers_empty_flag;
      end
    end
  end

endmodule
`default_nettype wire

// >>> tb/pdc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire peripheral_rx_request,
  input wire peripheral_tx_request,
  input wire [1:0] rx_size,
  input wire [1:0] tx_size,
  input wire rx_xfer_req,
  input wire [31:0] rx_xfer_addr,
  input wire rx_xfer_done,
  input wire tx_xfer_req,
  input wire [31:0] tx_xfer_addr,
  input wire tx_xfer_done,
  input wire rx_buffer_end_flag,
  input wire rx_all_buffers_full_flag,
  input wire tx_buffer_end_flag,
  input wire tx_all_buffers_empty_flag
);
  // ****************************************************************
  // bus writes win over hardware updates, so they mask every step check
  // ****************************************************************
  wire wr = psel && penable && pwrite;
  wire bad = paddr < 12'h100 || paddr > 12'h128 || paddr[1:0] != 2'h0;
  function automatic logic [31:0] stp(input logic [1:0] s);
    return s == 2'h1 ? 32'h2 : s == 2'h2 ? 32'h4 : 32'h1;
  endfunction
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rx_chain;
    rx_buffer_end_flag && !rx_all_buffers_full_flag && !wr;
  endsequence
  sequence s_tx_chain;
    tx_buffer_end_flag && !tx_all_buffers_empty_flag && !wr;
  endsequence
  a_rx_req_gate: assert property (rx_xfer_req |->
    peripheral_rx_request && !rx_buffer_end_flag) else $error("rx gate");
  a_tx_req_gate: assert property (tx_xfer_req |->
    peripheral_tx_request && !tx_buffer_end_flag) else $error("tx gate");
  a_rx_ptr_step: assert property (rx_xfer_req && rx_xfer_done && !wr
    |=> rx_xfer_addr == $past(rx_xfer_addr) + stp($past(rx_size)))
    else $error("rx step");
  a_tx_ptr_step: assert property (tx_xfer_req && tx_xfer_done && !wr
    |=> tx_xfer_addr == $past(tx_xfer_addr) + stp($past(tx_size)))
    else $error("tx step");
  a_rx_ptr_hold: assert property (!(rx_xfer_req && rx_xfer_done) &&
    !rx_buffer_end_flag && !wr |=> $stable(rx_xfer_addr))
    else $error("rx hold");
  a_rx_chain_go: assert property (s_rx_chain |=> !rx_buffer_end_flag)
    else $error("rx chain");
  a_tx_chain_go: assert property (s_tx_chain |=> !tx_buffer_end_flag)
    else $error("tx chain");
  a_flag_nest: assert property ((!rx_all_buffers_full_flag ||
    rx_buffer_end_flag) && (!tx_all_buffers_empty_flag || tx_buffer_end_flag))
    else $error("flag nest");
  a_slverr_map: assert property (psel && penable |-> pslverr == bad)
    else $error("slverr");
  a_bad_read: assert property (psel && !penable && !pwrite && bad
    |=> prdata == 32'h0) else $error("bad read");
endmodule
bind pdc_channel_pair pdc_monitor u_mon (.*);
`default_nettype wire

// >>> tb/pdc_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_far_side (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic rx_xfer_req,
  input wire logic tx_xfer_req,
  output logic peripheral_rx_request,
  output logic peripheral_tx_request,
  output logic rx_xfer_done,
  output logic tx_xfer_done
);
  // ****************************************************************
  // slow mode: requests rise late and stay up until served, answers lag
  // ****************************************************************
  logic [7:0] r_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= 8'h5A;
      {peripheral_rx_request, peripheral_tx_request} <= 2'h0;
      {rx_xfer_done, tx_xfer_done} <= 2'h0;
    end else begin
      r_q <= {r_q[6:0], r_q[7] ^ r_q[5] ^ r_q[4] ^ r_q[3]};
      peripheral_rx_request <= !slow || r_q[0] ||
        (peripheral_rx_request && !rx_xfer_done);
      peripheral_tx_request <= !slow || r_q[1] ||
        (peripheral_tx_request && !tx_xfer_done);
      rx_xfer_done <= rx_xfer_req && !rx_xfer_done && (!slow || r_q[2]);
      tx_xfer_done <= tx_xfer_req && !tx_xfer_done && (!slow || r_q[3]);
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_peripheral_dma_channel_pair.sv
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_dma_channel_pair;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, slow = 1'h0, err_q;
  logic [11:0] paddr = 12'h0, ad;
  logic [31:0] pwdata = 32'h0, lf = 32'h387C55B4, rd_q, p;
  logic [1:0] rx_size = 2'h0, tx_size = 2'h0;
  wire [31:0] prdata, rx_xfer_addr, tx_xfer_addr;
  wire pready, pslverr, rx_xfer_req, tx_xfer_req, rx_xfer_done;
  wire tx_xfer_done, peripheral_rx_request, peripheral_tx_request;
  wire rx_buffer_end_flag, rx_all_buffers_full_flag;
  wire tx_buffer_end_flag, tx_all_buffers_empty_flag;
  int error_cnt = 0, checked = 0, n;
  logic [31:0] cmd_t [10] = '{32'h1, 32'h0, 32'h2, 32'h3, 32'h100, 32'h0,
    32'h200, 32'h300, 32'h101, 32'hFFFFFCFC};
  logic [31:0] st_t [10] = '{32'h1, 32'h1, 32'h0, 32'h0, 32'h100, 32'h100,
    32'h0, 32'h0, 32'h101, 32'h101};
  always #2.5 pclk = ~pclk;
  pdc_channel_pair DUT (.*);
  pdc_far_side u_far (.*);
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] stp(input logic [1:0] s);
    return s == 2'h1 ? 32'h2 : s == 2'h2 ? 32'h4 : 32'h1;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ****************************************************************
  // apb master: setup, then access held until pready is seen high
  // ****************************************************************
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    rd_q = prdata;
    err_q = pslverr;
    {psel, penable} <= 2'h0;
    if (k >= 50) begin
      error_cnt++;
      conclude();
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    for (int a = 'h100; a <= 'h128; a += 4) begin
      apb(1'h0, 12'(a), 32'h0);
      chk(rd_q, a == 'h128 ? 32'hF : 32'h0);
    end
    apb(1'h0, 12'h12C, 32'h0);
    chk({rd_q[30:0], err_q}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      apb(1'h1, 12'(12'h100 + 4 * i), lf);
      apb(1'h0, 12'(12'h100 + 4 * i), 32'h0);
      chk(rd_q, i[0] ? lf & 32'hFFFF : lf);
    end
    for (int i = 0; i < 10; i++) begin
      apb(1'h1, 12'h120, cmd_t[i]);
      apb(1'h0, 12'h124, 32'h0);
      chk(rd_q, st_t[i]);
    end
    for (int m = 0; m < 2; m++) begin
      apb(1'h1, 12'h120, 32'h202);
      lf = nxt(lf);
      slow <= m[0];
      {rx_size, tx_size} <= lf[3:0];
      for (int c = 0; c < 2; c++) begin
        ad = 12'(12'h100 + 8 * c);
        apb(1'h1, ad, lf);
        apb(1'h1, ad + 12'h4, 32'(m + 3));
        apb(1'h1, ad + 12'h10, ~lf);
        apb(1'h1, ad + 12'h14, 32'h2);
      end
      apb(1'h0, 12'h128, 32'h0);
      chk(rd_q, 32'h0);
      apb(1'h1, 12'h120, 32'h101);
      n = 0;
      while (!(rx_all_buffers_full_flag === 1'h1 &&
          tx_all_buffers_empty_flag === 1'h1) && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 2000) begin
        error_cnt++;
        conclude();
      end
      for (int c = 0; c < 2; c++) begin
        ad = 12'(12'h100 + 8 * c);
        p = ~lf + 32'h2 * stp(c == 0 ? rx_size : tx_size);
        apb(1'h0, ad, 32'h0);
        chk(rd_q, p);
        apb(1'h0, ad + 12'h4, 32'h0);
        chk(rd_q, 32'h0);
        apb(1'h0, ad + 12'h14, 32'h0);
        chk(rd_q, 32'h0);
      end
      apb(1'h0, 12'h128, 32'h0);
      chk(rd_q, 32'hF);
      apb(1'h1, 12'h120, 32'h202);
      apb(1'h1, 12'h104, 32'h5);
      apb(1'h0, 12'h128, 32'h0);
      chk(rd_q, 32'hC);
    end
    conclude();
  end
endmodule
`default_nettype wire
